// ---- hdl/easdu_params.svh ----
// Constants for the extended arithmetic shift and divide unit.
// Assumes a 20 MHz core clock and an APB register port.
`ifndef EASDU_PARAMS_SVH
`define EASDU_PARAMS_SVH

// Register byte offsets
`define EASDU_WORK_OFS      8'h00
`define EASDU_MQ_OFS        8'h04
`define EASDU_SC_OFS        8'h08
`define EASDU_FLAGS_OFS     8'h0C
`define EASDU_INSTR_OFS     8'h10
`define EASDU_OPERAND_OFS   8'h14

// Flag register field positions
`define EASDU_FLG_LINK      0
`define EASDU_FLG_OSIGN     1
`define EASDU_FLG_RSIGN     2
`define EASDU_FLG_BUSY      8
`define EASDU_FLG_OVF       9

// Reset values
`define EASDU_WORD_RST      18'h00000
`define EASDU_SC_RST        6'h00

// Instruction fields (hardware bit 0 is the least significant)
`define EASDU_OPCODE        4'hD
`define EASDU_NORM_CNT      6'h24

// Timing in ns and derived cycle counts
`define EASDU_CLK_NS        50
`define EASDU_FIXED_NS      1600
`define EASDU_STEP_NS       100
`define EASDU_DIV_STEP_NS   400
`define EASDU_MUL_ADD_NS    250
`define EASDU_DIV_OVF_NS    3500
`define EASDU_CYC(ns)       (((ns) + `EASDU_CLK_NS - 1) / `EASDU_CLK_NS)
`define EASDU_FIXED_CYC     `EASDU_CYC(`EASDU_FIXED_NS)
`define EASDU_STEP_CYC      `EASDU_CYC(`EASDU_STEP_NS)
`define EASDU_DIV_STEP_CYC  `EASDU_CYC(`EASDU_DIV_STEP_NS)
`define EASDU_MUL_ADD_CYC   `EASDU_CYC(`EASDU_MUL_ADD_NS)
`define EASDU_DIV_OVF_CYC   `EASDU_CYC(`EASDU_DIV_OVF_NS)

`endif

// ---- hdl/easdu_pkg.sv ----
// Types of the extended arithmetic shift and divide unit.
// Assumes easdu_params.svh for numeric constants.
package easdu_pkg;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } easdu_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } easdu_apb_rsp_t;

    // Function codes; all but setup and reserved are stepped
    typedef enum logic [2:0] {
        EASDU_FN_SETUP = 3'b000,
        EASDU_FN_MUL   = 3'b001,
        EASDU_FN_RSVD  = 3'b010,
        EASDU_FN_DIV   = 3'b011,
        EASDU_FN_NORM  = 3'b100,
        EASDU_FN_LRS   = 3'b101,
        EASDU_FN_LLS   = 3'b110,
        EASDU_FN_ALS   = 3'b111
    } easdu_fn_t;

    // Sequencer phases
    typedef enum logic [1:0] {
        EASDU_PH_IDLE  = 2'b00,
        EASDU_PH_FIXED = 2'b01,
        EASDU_PH_STEP  = 2'b10
    } easdu_phase_t;

    // Whole state of the unit
    typedef struct packed {
        logic [17:0]    work_register;
        logic [17:0]    multiplier_quotient_register;
        logic [5:0]     step_counter;
        logic           link;
        logic           operand_sign;
        logic           result_sign;
        logic           overflow;
        logic           first_step;
        logic [17:0]    operand;
        logic [17:0]    instr;
        easdu_fn_t      fn;
        easdu_phase_t   phase;
        logic [7:0]     timer;
        easdu_apb_rsp_t rsp;
    } easdu_state_t;

endpackage

// ---- hdl/easdu.sv ----
// Extended arithmetic unit: stepped multiply, divide, shifts, normalize.
// Assumes an APB master on core_clk; instruction and operand are written
// by software, the instruction write starts the operation.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`include "easdu_params.svh"

module easdu
    import easdu_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire easdu_apb_req_t apb_req,
    output easdu_apb_rsp_t      apb_rsp,
    output logic                busy
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    generate
        if (ADDR_W != 8) begin : g_bad_addr
            $error("easdu: ADDR_W must be 8");
        end
    endgenerate

    localparam logic [7:0] FIXED_CYC  = 8'(`EASDU_FIXED_CYC);
    localparam logic [7:0] STEP_CYC   = 8'(`EASDU_STEP_CYC);
    localparam logic [7:0] DSTEP_CYC  = 8'(`EASDU_DIV_STEP_CYC);
    localparam logic [7:0] MADD_CYC   = 8'(`EASDU_MUL_ADD_CYC);
    localparam logic [7:0] DOVF_CYC   = 8'(`EASDU_DIV_OVF_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Zero-extend an 18-bit word to the bus width
    function automatic logic [31:0] word32(input logic [17:0] w);
        word32 = {14'h0000, w};
    endfunction

    // Per-step wait after a performed step, minus one
    function automatic logic [7:0] step_wait(input easdu_fn_t f,
                                             input logic add);
        logic [7:0] c;
        c = STEP_CYC;
        if (f == EASDU_FN_DIV) begin
            c = DSTEP_CYC;
        end else if (f == EASDU_FN_MUL && add) begin
            c = STEP_CYC + MADD_CYC;
        end
        step_wait = c - 8'h01;
    endfunction

    easdu_state_t st_reg;
    easdu_state_t st_next;

    logic        acc_wr;
    logic        setup_ph;
    logic [7:0]  addr;
    logic [17:0] a;
    logic [17:0] m;
    logic        l;
    logic [17:0] ir;
    logic [18:0] sum;
    logic [18:0] trial;
    logic        stop;

    assign apb_rsp = st_reg.rsp;
    assign addr    = apb_req.paddr;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_next  = st_reg;
        setup_ph = apb_req.psel && !apb_req.penable;
        acc_wr   = apb_req.psel && apb_req.penable && st_reg.rsp.pready
                   && apb_req.pwrite;
        a        = st_reg.work_register;
        m        = st_reg.multiplier_quotient_register;
        l        = st_reg.link;
        ir       = apb_req.pwdata[17:0];
        sum      = 19'h00000;
        trial    = 19'h00000;
        stop     = 1'b0;

        // Answer in the first access cycle, data prepared at setup
        st_next.rsp.pready  = setup_ph;
        st_next.rsp.pslverr = 1'b0;
        st_next.rsp.prdata  = 32'h00000000;
        if (setup_ph) begin
            case (addr)
                `EASDU_WORK_OFS:
                    st_next.rsp.prdata = word32(st_reg.work_register);
                `EASDU_MQ_OFS:
                    st_next.rsp.prdata =
                        word32(st_reg.multiplier_quotient_register);
                `EASDU_SC_OFS:
                    st_next.rsp.prdata = {26'h0000000, st_reg.step_counter};
                `EASDU_FLAGS_OFS: begin
                    st_next.rsp.prdata[`EASDU_FLG_LINK]  = st_reg.link;
                    st_next.rsp.prdata[`EASDU_FLG_OSIGN] =
                        st_reg.operand_sign;
                    st_next.rsp.prdata[`EASDU_FLG_RSIGN] =
                        st_reg.result_sign;
                    st_next.rsp.prdata[`EASDU_FLG_BUSY]  =
                        (st_reg.phase != EASDU_PH_IDLE);
                    st_next.rsp.prdata[`EASDU_FLG_OVF]   = st_reg.overflow;
                end
                `EASDU_INSTR_OFS:
                    st_next.rsp.prdata = word32(st_reg.instr);
                `EASDU_OPERAND_OFS:
                    st_next.rsp.prdata = word32(st_reg.operand);
                default: begin
                    st_next.rsp.pslverr = 1'b1;
                end
            endcase
            // Bad opcode in an instruction write is refused
            if (apb_req.pwrite && addr == `EASDU_INSTR_OFS
                && apb_req.pwdata[17:14] != `EASDU_OPCODE) begin
                st_next.rsp.pslverr = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Register writes and instruction issue, idle only
        if (acc_wr && st_reg.phase == EASDU_PH_IDLE) begin
            case (addr)
                `EASDU_WORK_OFS:
                    st_next.work_register = apb_req.pwdata[17:0];
                `EASDU_MQ_OFS:
                    st_next.multiplier_quotient_register =
                        apb_req.pwdata[17:0];
                `EASDU_SC_OFS:
                    st_next.step_counter = apb_req.pwdata[5:0];
                `EASDU_FLAGS_OFS: begin
                    st_next.link = apb_req.pwdata[`EASDU_FLG_LINK];
                    st_next.operand_sign =
                        apb_req.pwdata[`EASDU_FLG_OSIGN];
                    st_next.result_sign =
                        apb_req.pwdata[`EASDU_FLG_RSIGN];
                end
                `EASDU_OPERAND_OFS:
                    st_next.operand = apb_req.pwdata[17:0];
                `EASDU_INSTR_OFS: begin
                    if (ir[17:14] == `EASDU_OPCODE) begin
                        st_next.instr = ir;
                        st_next.fn    = easdu_fn_t'(ir[8:6]);
                        if (ir[13]) begin
                            l = a[17];
                        end
                        // Clear quotient register
                        if (ir[12]) begin
                            m = 18'h00000;
                        end
                        if (ir[11]) begin
                            st_next.operand_sign = a[17];
                            if (!ir[10] && a[17]) begin
                                a = ~a;
                            end
                        end
                        if (ir[10]) begin
                            m = m | a;
                        end
                        // Clear work register
                        if (ir[9]) begin
                            a = 18'h00000;
                        end
                        if (ir[8:6] == EASDU_FN_SETUP) begin
                            if (ir[2]) begin
                                m = ~m;
                            end
                            if (ir[1]) begin
                                a = a | m;
                            end
                            if (ir[0]) begin
                                a[5:0] = a[5:0] | st_reg.step_counter;
                            end
                        end else begin
                            st_next.step_counter = ir[5:0];
                        end
                        if (ir[8:6] != EASDU_FN_SETUP
                            && ir[8:6] != EASDU_FN_RSVD) begin
                            st_next.phase        = EASDU_PH_FIXED;
                            st_next.timer        = FIXED_CYC - 8'h01;
                            st_next.first_step   = 1'b1;
                            st_next.overflow     = 1'b0;
                            if (ir[8:6] == EASDU_FN_MUL) begin
                                if (st_next.operand_sign) begin
                                    m = ~m;
                                end
                                st_next.result_sign =
                                    st_next.operand_sign ^ l;
                            end
                            if (ir[8:6] == EASDU_FN_DIV) begin
                                st_next.result_sign = ir[11]
                                    ? st_next.operand_sign ^ l : a[17] ^ l;
                                if (st_next.operand_sign) begin
                                    m = ~m;
                                end
                                if (a >= st_reg.operand) begin
                                    st_next.overflow = 1'b1;
                                    st_next.timer = DOVF_CYC - 8'h01;
                                end
                            end
                        end
                        st_next.work_register = a;
                        st_next.multiplier_quotient_register = m;
                        st_next.link = l;
                    end
                end
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Stepped sequencer
        case (st_reg.phase)
            EASDU_PH_IDLE: ;
            EASDU_PH_FIXED: begin
                if (st_reg.timer != 8'h00) begin
                    st_next.timer = st_reg.timer - 8'h01;
                end else if (st_reg.overflow) begin
                    st_next.link  = 1'b1;
                    st_next.phase = EASDU_PH_IDLE;
                end else begin
                    st_next.phase = EASDU_PH_STEP;
                end
            end
            EASDU_PH_STEP: begin
                stop = (st_reg.step_counter == 6'h00)
                       || (st_reg.fn == EASDU_FN_NORM && a[17] != a[16]);
                if (st_reg.timer != 8'h00) begin
                    st_next.timer = st_reg.timer - 8'h01;
                end else if (stop) begin
                    st_next.phase = EASDU_PH_IDLE;
                    case (st_reg.fn)
                        EASDU_FN_MUL: begin
                            st_next.link = 1'b0;
                            if (st_reg.result_sign) begin
                                st_next.work_register = ~a;
                                st_next.multiplier_quotient_register = ~m;
                            end
                        end
                        EASDU_FN_DIV: begin
                            st_next.link = 1'b0;
                            if (st_reg.result_sign) begin
                                st_next.multiplier_quotient_register = ~m;
                            end
                            if (st_reg.operand_sign) begin
                                st_next.work_register = ~a;
                            end
                        end
                        EASDU_FN_NORM: begin
                            st_next.step_counter =
                                6'h00 - st_reg.step_counter;
                        end
                        default: ;
                    endcase
                end else begin
                    st_next.step_counter = st_reg.step_counter - 6'h01;
                    st_next.first_step   = 1'b0;
                    st_next.timer = step_wait(st_reg.fn, m[0]);
                    case (st_reg.fn)
                        EASDU_FN_MUL: begin
                            sum = m[0] ? ({1'b0, a} + {1'b0, st_reg.operand})
                                       : {1'b0, a};
                            st_next.work_register = sum[18:1];
                            st_next.multiplier_quotient_register =
                                {sum[0], m[17:1]};
                        end
                        EASDU_FN_DIV: begin
                            // First step only counts down, no compare and no shift
                            if (!st_reg.first_step) begin
                                trial = {a, m[17]};
                                if (trial >= {1'b0, st_reg.operand}) begin
                                    trial = trial - {1'b0, st_reg.operand};
                                    st_next.multiplier_quotient_register =
                                        {m[16:0], 1'b1};
                                end else begin
                                    st_next.multiplier_quotient_register =
                                        {m[16:0], 1'b0};
                                end
                                st_next.work_register = trial[17:0];
                            end
                        end
                        EASDU_FN_LRS: begin
                            st_next.work_register = {l, a[17:1]};
                            st_next.multiplier_quotient_register =
                                {a[0], m[17:1]};
                        end
                        EASDU_FN_LLS, EASDU_FN_NORM: begin
                            st_next.work_register = {a[16:0], m[17]};
                            st_next.multiplier_quotient_register =
                                {m[16:0], l};
                        end
                        EASDU_FN_ALS: begin
                            st_next.work_register = {a[16:0], l};
                        end
                        default: ;
                    endcase
                end
            end
            default: begin
                st_next.phase = EASDU_PH_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg.work_register                <= `EASDU_WORD_RST;
            st_reg.multiplier_quotient_register <= `EASDU_WORD_RST;
            st_reg.step_counter                 <= `EASDU_SC_RST;
            st_reg.link                         <= 1'b0;
            st_reg.operand_sign                 <= 1'b0;
            st_reg.result_sign                  <= 1'b0;
            st_reg.overflow                     <= 1'b0;
            st_reg.first_step                   <= 1'b0;
            st_reg.operand                      <= `EASDU_WORD_RST;
            st_reg.instr                        <= `EASDU_WORD_RST;
            st_reg.fn                           <= EASDU_FN_SETUP;
            st_reg.phase                        <= EASDU_PH_IDLE;
            st_reg.timer                        <= 8'h00;
            st_reg.rsp                          <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Busy flag from its own flop
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (st_next.phase != EASDU_PH_IDLE);
        end
    end

endmodule

// ---- test/easdu_assertions.sv ----
// Port checker for the arithmetic unit.
// Assumes a zero-wait APB slave; bound into every easdu.
`timescale 1ns/100ps
`include "easdu_params.svh"
module easdu_assertions
    import easdu_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           sys_rst,
    input wire easdu_apb_req_t apb_req,
    input wire easdu_apb_rsp_t apb_rsp,
    input wire logic           busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic       setup_c;
    logic       bad_c;
    logic       issue_c;
    logic [2:0] fn_c;
    // Setup cycle, idle instruction write and legal issue
    assign setup_c = apb_req.psel && !apb_req.penable;
    assign fn_c = apb_req.pwdata[8:6];
    assign bad_c = setup_c && apb_req.pwrite && !busy
        && apb_req.paddr == `EASDU_INSTR_OFS;
    assign issue_c = bad_c && apb_req.pwdata[17:14] == `EASDU_OPCODE;
    ready_access_a: assert property (setup_c |=> apb_rsp.pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (
        apb_rsp.pready |=> !apb_rsp.pready) else $error("ready too long");
    unmapped_err_a: assert property (setup_c && apb_req.paddr > 8'h14
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped");
    upper_zero_a: assert property (apb_rsp.pready && !apb_req.pwrite
        |-> apb_rsp.prdata[31:18] == 14'h0) else $error("upper bits set");
    bad_opcode_a: assert property (bad_c && !issue_c
        |=> apb_rsp.pslverr ##1 !busy) else $error("bad opcode taken");
    setup_quick_a: assert property (issue_c && fn_c == 3'b000
        |=> ##1 !busy) else $error("setup raised busy");
    busy_cause_a: assert property ($rose(busy) |-> $past(issue_c, 2))
        else $error("busy without issue");
    shift_time_a: assert property (issue_c && fn_c[2]
        |=> ##1 (busy throughout (##31 1'b1)) ##[1:140] !busy)
        else $error("shift time");
    div_time_a: assert property (issue_c && fn_c == 3'b011
        |=> ##1 (busy throughout (##63 1'b1)) ##[1:600] !busy)
        else $error("divide time");
    shift_seen_c: cover property (issue_c && fn_c[2]);
    div_seen_c: cover property (issue_c && fn_c == 3'b011);
    error_seen_c: cover property (apb_rsp.pslverr);
endmodule
bind easdu easdu_assertions easdu_assertions_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .busy(busy));

// ---- test/easdu_cpu_model.sv ----
// Processor side: issues register and instruction transfers over APB.
// Assumes the unit answers each access phase with pready.
`timescale 1ns/100ps
module easdu_cpu_model
    import easdu_pkg::*;
(
    input  wire logic           core_clk,
    output easdu_apb_req_t      apb_req,
    input  wire easdu_apb_rsp_t apb_rsp
);
    // Idle bus from time zero
    initial apb_req = '0;
    // Setup, then access held until pready
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        apb_req.pwdata <= ~d; // Released data does not linger
    endtask
endmodule

// ---- test/easdu_test.sv ----
// Bench for the arithmetic unit: operation table, then edge cases.
// Assumes the processor model as master and the bound checker.
`timescale 1ns/100ps
`include "easdu_params.svh"
module easdu_test
    import easdu_pkg::*;
;
    typedef struct packed {
        logic [17:0] ins, w, q, op;
        logic [5:0]  sc;
        logic        l;
        logic [17:0] ew, eq;
        logic [5:0]  esc;
        logic        el;
        logic [8:0]  cyc;
    } easdu_row_t;
    logic           core_clk = 1'b0;
    logic           sys_rst = 1'b1;
    easdu_apb_req_t apb_req;
    easdu_apb_rsp_t apb_rsp;
    logic           busy;
    logic [31:0]    rd;
    logic           er;
    int             n;
    int             mismatches = 0;
    int             checked = 0;
    // Set-up values, then expected results and busy cycles
    easdu_row_t rows [13] = '{
      '{18'h34143,18'h20005,18'h00003,18'h0,6'h0,1'b1, // long right
        18'h3C000,18'h28000,6'h0,1'b1,9'h027},
      '{18'h34182,18'h00001,18'h20000,18'h0,6'h0,1'b1, // long left
        18'h00006,18'h00003,6'h0,1'b1,9'h025},
      '{18'h341C4,18'h00003,18'h12345,18'h0,6'h0,1'b0, // work only
        18'h00030,18'h12345,6'h0,1'b0,9'h029},
      '{18'h34124,18'h04000,18'h0,18'h0,6'h0,1'b0, // normalize
        18'h10000,18'h0,6'h1E,1'b0,9'h025},
      '{18'h36141,18'h20000,18'h0,18'h0,6'h0,1'b0, // signed
        18'h30000,18'h0,6'h0,1'b1,9'h023},
      '{18'h34004,18'h0,18'h0F0F0,18'h0,6'h15,1'b0, // complement
        18'h0,18'h30F0F,6'h15,1'b0,9'h0},
      '{18'h34002,18'h00011,18'h10100,18'h0,6'h15,1'b0, // or
        18'h10111,18'h10100,6'h15,1'b0,9'h0},
      '{18'h34001,18'h00100,18'h0,18'h0,6'h2A,1'b0, // count
        18'h0012A,18'h0,6'h2A,1'b0,9'h0},
      '{18'h34000,18'h12345,18'h0ABCD,18'h0,6'h07,1'b1, // no op
        18'h12345,18'h0ABCD,6'h07,1'b1,9'h0},
      '{18'h35652,18'h00064,18'h3FFFF,18'h0012C,6'h0,1'b0,
        18'h0,18'h07530,6'h0,1'b0,9'h054},
      '{18'h348D3,18'h3FFFF,18'h3FF9B,18'h00007,6'h0,1'b0,
        18'h3FFFD,18'h3FFF1,6'h0,1'b0,9'h0B9},
      '{18'h340D3,18'h00010,18'h01234,18'h00005,6'h0,1'b0, // overflow
        18'h00010,18'h01234,6'h13,1'b1,9'h046},
      '{18'h35E52,18'h3FFFC,18'h0,18'h00005,6'h0,1'b0, // signed mul
        18'h3FFFF,18'h3FFF0,6'h0,1'b0,9'h04F}};
    easdu easdu_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .busy(busy));
    easdu_cpu_model easdu_cpu_model_inst (.core_clk(core_clk),
        .apb_req(apb_req), .apb_rsp(apb_rsp));
    // Free-running core clock
    always #25 core_clk = ~core_clk;
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        easdu_cpu_model_inst.xfer(w, a, d, rd, er);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Counts busy cycles, bounded
    task automatic wait_idle;
        n = 0;
        @(posedge core_clk);
        while (busy === 1'b1 && n < 600) begin
            n++;
            @(posedge core_clk);
        end
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            acc(1'b1, `EASDU_WORK_OFS, {14'h0, rows[i].w});
            acc(1'b1, `EASDU_MQ_OFS, {14'h0, rows[i].q});
            acc(1'b1, `EASDU_SC_OFS, {26'h0, rows[i].sc});
            acc(1'b1, `EASDU_FLAGS_OFS, {31'h0, rows[i].l});
            acc(1'b1, `EASDU_OPERAND_OFS, {14'h0, rows[i].op});
            acc(1'b1, `EASDU_INSTR_OFS, {14'h0, rows[i].ins});
            wait_idle();
            check(n, {23'h0, rows[i].cyc});
            rdchk(`EASDU_WORK_OFS, {14'h0, rows[i].ew});
            rdchk(`EASDU_MQ_OFS, {14'h0, rows[i].eq});
            rdchk(`EASDU_SC_OFS, {26'h0, rows[i].esc});
            acc(1'b0, `EASDU_FLAGS_OFS, 32'h0);
            check({29'h0, rd[9:8], rd[0]},
                  {29'h0, i == 11, 1'b0, rows[i].el});
        end
        // Work write during a long shift is dropped
        acc(1'b1, `EASDU_WORK_OFS, 32'h0);
        acc(1'b1, `EASDU_FLAGS_OFS, 32'h0);
        acc(1'b1, `EASDU_INSTR_OFS, 32'h00034141);
        acc(1'b1, `EASDU_WORK_OFS, 32'h0003FFFF);
        wait_idle();
        rdchk(`EASDU_WORK_OFS, 32'h0);
        // Unmapped read and bad opcode answer with an error
        acc(1'b0, 8'h40, 32'h0);
        check({er, rd[30:0]}, 32'h80000000);
        acc(1'b1, `EASDU_INSTR_OFS, 32'h00000140);
        check({31'h0, er}, 32'h1);
        // Reserved function loads the count, starts nothing
        acc(1'b1, `EASDU_INSTR_OFS, 32'h00034085);
        check({31'h0, er}, 32'h0);
        rdchk(`EASDU_SC_OFS, 32'h5);
        acc(1'b0, `EASDU_FLAGS_OFS, 32'h0);
        check({31'h0, rd[8]}, 32'h0);
        // Reset after an idle work write clears every register
        acc(1'b1, `EASDU_WORK_OFS, 32'h00000005);
        sys_rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 24; a += 4)
            rdchk(8'(a), 32'h0);
        stop_test();
    end
endmodule
